// [logic/rsc_pkg.sv]
// constants and types shared by the radio sequencer control register bank
package rsc_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_OPERAND_X  = 16'hdf12;
  localparam logic [15:0] IDX_OPERAND_Y  = 16'hdf13;
  localparam logic [15:0] IDX_OPERAND_Z  = 16'hdf14;
  localparam logic [15:0] IDX_CONDITION  = 16'hdf15;
  localparam logic [15:0] IDX_LOOP_CNT   = 16'hdf16;
  localparam logic [15:0] IDX_REG_POWER  = 16'hdf17;
  localparam logic [15:0] IDX_TIMING_HI  = 16'hdf20;
  localparam logic [15:0] IDX_TIMING_LO  = 16'hdf21;
  localparam logic [15:0] IDX_AND_MASK_H = 16'hdf22;
  localparam int          ADDR_W         = 18;

  // reset values
  localparam logic [7:0] RST_OPERAND    = 8'h00;
  localparam logic [7:0] RST_LOOP_CNT   = 8'h00;
  localparam logic       RST_CONDITION  = 1'b0;
  localparam logic       RST_REG_OFF    = 1'b1;
  localparam logic [2:0] RST_REG_DELAY  = 3'b100;
  localparam logic [2:0] RST_RX2DEMOD   = 3'b011;
  localparam logic [2:0] RST_SW_LEAD    = 3'b110;
  localparam logic [1:0] RST_PA_LEAD_HI = 2'b10;
  localparam logic [1:0] RST_PA_LEAD_LO = 2'b10;
  localparam logic [2:0] RST_END2SW     = 3'b010;
  localparam logic [2:0] RST_END2PA     = 3'b100;
  localparam logic [7:0] RST_AND_MASK   = 8'hbf;
  localparam logic [7:0] LOOP_NO_DEC    = 8'hff;

  // field positions
  localparam int POS_REG_OFF     = 3;
  localparam int POS_REG_OFF_DLY = 4;
  localparam int POS_RX2DEMOD    = 5;
  localparam int POS_SW_LEAD     = 2;
  localparam int POS_PA_LEAD_LO  = 6;
  localparam int POS_END2SW      = 3;
  localparam int POS_END2PA      = 0;
  localparam int POS_VGA_RST_N   = 7;
  localparam int POS_EXT_BIAS    = 5;
  localparam int POS_BUF_SEL     = 4;
  localparam int POS_PRESCALER   = 3;
  localparam int POS_PA_NEG      = 2;
  localparam int POS_PA_POS      = 1;
  localparam int POS_TX_DAC      = 0;

  // timing
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int US_PS           = 1000000;
  localparam int US_CYCLES       = US_PS / CLK_PERIOD_PS;
  localparam int SYMBOL_US       = 16;
  localparam int CAL_HALF_SYMB   = 13;
  localparam int CAL_US          = (CAL_HALF_SYMB * SYMBOL_US + 1) / 2;
  localparam int RX_STEP_US      = 5;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_LEAD = 3'b001,
    TX_ON   = 3'b010,
    TX_TAIL = 3'b011
  } rsc_tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_CAL   = 2'b01,
    RX_CHAIN = 2'b10,
    RX_DEMOD = 2'b11
  } rsc_rx_state_type;

  // analogue control lines after masking
  typedef struct packed {
    logic vga_reset_n;
    logic pa_external_bias_ctl;
    logic buffer_select;
    logic prescaler_off;
    logic pa_negative_path_off;
    logic pa_positive_path_off;
    logic tx_converter_off;
    logic upmixer_off;
  } rsc_analog_type;

  // operand registers seen by the sequencer
  typedef struct packed {
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
    logic       condition;
  } rsc_operands_type;

  // regulator on-delay in microseconds per code
  function automatic logic [10:0] reg_delay_us(input logic [2:0] code);
    case (code)
      3'b000:  reg_delay_us = 11'd0;
      3'b001:  reg_delay_us = 11'd31;
      3'b010:  reg_delay_us = 11'd63;
      3'b011:  reg_delay_us = 11'd125;
      3'b100:  reg_delay_us = 11'd250;
      3'b101:  reg_delay_us = 11'd500;
      3'b110:  reg_delay_us = 11'd1000;
      default: reg_delay_us = 11'd2000;
    endcase
  endfunction
endpackage

// [logic/rsc_regs.sv]
// radio sequencer control register bank with radio timing engine and mask
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
// Operation
// - timer overflow while running decrements loop counter
// - halt program when counter about to reach zero
// - all-ones loop counter is never decremented
// - X operand feeds sequencer, resets to zero
// - Y operand used and updated by sequencer
// - Z operand decremented by sequencer, evaluated
// - condition bit writable, bits 7:1 read zero
// - regulator off bit, set powers down, resets one
// - read-only delayed copy of regulator off bit
// - delay code selects 0 to 2000 us
// - demodulator enabled field times 5 us later
// - RX chain starts after 6.5 symbol calibration
// - switch raised programmed us before TX
// - PA powered programmed us before TX, split field
// - switch dropped programmed us after last chip
// - PA and modulator off programmed us after end
// - mask bit 7 gates VGA peak reset
// - mask bit 5 gates PA external bias
// - mask bit 4 gates buffer select
// - both PA paths off also powers mixers down
// - mask bits 3..0 gate power-down lines
module rsc_regs (
  input  wire logic                       sys_clk_in,
  input  wire logic                       arst_n_in,
  input  wire logic [rsc_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                       s_axi_awvalid_in,
  output logic                            s_axi_awready_out,
  input  wire logic [31:0]                s_axi_wdata_in,
  input  wire logic [3:0]                 s_axi_wstrb_in,
  input  wire logic                       s_axi_wvalid_in,
  output logic                            s_axi_wready_out,
  output logic [1:0]                      s_axi_bresp_out,
  output logic                            s_axi_bvalid_out,
  input  wire logic                       s_axi_bready_in,
  input  wire logic [rsc_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                       s_axi_arvalid_in,
  output logic                            s_axi_arready_out,
  output logic [31:0]                     s_axi_rdata_out,
  output logic [1:0]                      s_axi_rresp_out,
  output logic                            s_axi_rvalid_out,
  input  wire logic                       s_axi_rready_in,
  input  wire logic                       seq_running_in,
  input  wire logic                       timer_overflow_in,
  input  wire logic                       seq_y_load_in,
  input  wire logic [7:0]                 seq_y_value_in,
  input  wire logic                       seq_z_dec_in,
  input  wire logic                       rx_request_in,
  input  wire logic                       tx_request_in,
  input  wire logic                       tx_last_chip_in,
  output rsc_pkg::rsc_operands_type       seq_operands_out,
  output logic                            seq_halt_out,
  output logic                            regulator_off_out,
  output logic                            rx_chain_en_out,
  output logic                            demod_en_out,
  output logic                            tx_en_out,
  output logic                            modulator_en_out,
  output rsc_pkg::rsc_analog_type         analog_out
);
  // register storage
  logic [7:0]  x_q, y_q, z_q, loop_q, mask_q;
  logic        cond_q, reg_off_q, reg_off_dly_q;
  logic [2:0]  reg_delay_q, rx2demod_q, sw_lead_q, end2sw_q, end2pa_q;
  logic [3:0]  pa_lead_q;
  logic        halt_q;
  // bus channel state
  logic        aw_full_q, w_full_q;
  logic [rsc_pkg::ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_go, wr_hit, rd_hit;
  logic [7:0]  rd_byte;
  logic [15:0] wr_idx;
  // timing
  logic [7:0]  us_div_q;
  logic        us_tick;
  logic [10:0] reg_cnt_q;
  logic [7:0]  rx_cnt_q, tx_cnt_q;
  logic        rx_req_q;
  logic        sw_on_q, pa_on_q, tx_on_q, mod_on_q;
  rsc_pkg::rsc_rx_state_type rx_state_q;
  rsc_pkg::rsc_tx_state_type tx_state_q;
  logic [3:0]  lead_max;
  rsc_pkg::rsc_analog_type lines;

  function automatic logic mapped(input logic [15:0] idx);
    mapped = (idx >= rsc_pkg::IDX_OPERAND_X && idx <= rsc_pkg::IDX_REG_POWER) ||
             (idx >= rsc_pkg::IDX_TIMING_HI && idx <= rsc_pkg::IDX_AND_MASK_H);
  endfunction

  function automatic logic [15:0] word_idx(input logic [rsc_pkg::ADDR_W-1:0] a);
    word_idx = a[rsc_pkg::ADDR_W-1:2];
  endfunction

  // write channels: address and data in either order
  assign wr_go  = aw_full_q && w_full_q && !s_axi_bvalid_out;
  assign wr_idx = word_idx(aw_addr_q);
  assign wr_hit = wr_go && mapped(wr_idx) && w_strb_q[0];

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aw_full_q         <= 1'b0;
      aw_addr_q         <= '0;
      s_axi_awready_out <= 1'b0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_full_q         <= 1'b1;
      aw_addr_q         <= s_axi_awaddr_in;
      s_axi_awready_out <= 1'b0;
    end else if (wr_go) begin
      aw_full_q         <= 1'b0;
    end else begin
      s_axi_awready_out <= !aw_full_q && !s_axi_awready_out;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      w_full_q         <= 1'b0;
      w_data_q         <= '0;
      w_strb_q         <= '0;
      s_axi_wready_out <= 1'b0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_full_q         <= 1'b1;
      w_data_q         <= s_axi_wdata_in;
      w_strb_q         <= s_axi_wstrb_in;
      s_axi_wready_out <= 1'b0;
    end else if (wr_go) begin
      w_full_q         <= 1'b0;
    end else begin
      s_axi_wready_out <= !w_full_q && !s_axi_wready_out;
    end
  end

  // unmapped index: slave error, nothing stored
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= mapped(wr_idx) ? 2'b00 : 2'b10;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // read channel: one cycle from address to data
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = mapped(word_idx(s_axi_araddr_in));
    case (word_idx(s_axi_araddr_in))
      rsc_pkg::IDX_OPERAND_X:  rd_byte = x_q;
      rsc_pkg::IDX_OPERAND_Y:  rd_byte = y_q;
      rsc_pkg::IDX_OPERAND_Z:  rd_byte = z_q;
      rsc_pkg::IDX_CONDITION:  rd_byte = {7'b000_0000, cond_q};
      rsc_pkg::IDX_LOOP_CNT:   rd_byte = loop_q;
      rsc_pkg::IDX_REG_POWER:  rd_byte = {3'b000, reg_off_dly_q, reg_off_q, reg_delay_q};
      rsc_pkg::IDX_TIMING_HI:  rd_byte = {rx2demod_q, sw_lead_q, pa_lead_q[3:2]};
      rsc_pkg::IDX_TIMING_LO:  rd_byte = {pa_lead_q[1:0], end2sw_q, end2pa_q};
      rsc_pkg::IDX_AND_MASK_H: rd_byte = {mask_q[7], 1'b0, mask_q[5:0]};
      default:                 rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= '0;
      s_axi_rresp_out   <= 2'b00;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= {24'h00_0000, rd_byte};
      s_axi_rresp_out   <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid_out) begin
      s_axi_rvalid_out  <= !s_axi_rready_in;
    end else begin
      s_axi_arready_out <= !s_axi_arready_out;
    end
  end

  // sequencer updates beat a same-cycle software write
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      x_q    <= rsc_pkg::RST_OPERAND;
      y_q    <= rsc_pkg::RST_OPERAND;
      z_q    <= rsc_pkg::RST_OPERAND;
      cond_q <= rsc_pkg::RST_CONDITION;
    end else begin
      if (wr_hit && wr_idx == rsc_pkg::IDX_OPERAND_X) x_q <= w_data_q[7:0];
      if (seq_y_load_in) y_q <= seq_y_value_in;
      else if (wr_hit && wr_idx == rsc_pkg::IDX_OPERAND_Y) y_q <= w_data_q[7:0];
      if (seq_z_dec_in) z_q <= z_q - 8'h01;
      else if (wr_hit && wr_idx == rsc_pkg::IDX_OPERAND_Z) z_q <= w_data_q[7:0];
      if (wr_hit && wr_idx == rsc_pkg::IDX_CONDITION) cond_q <= w_data_q[0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      loop_q <= rsc_pkg::RST_LOOP_CNT;
      halt_q <= 1'b0;
    end else begin
      halt_q <= 1'b0;
      if (seq_running_in && timer_overflow_in && loop_q != rsc_pkg::LOOP_NO_DEC) begin
        loop_q <= loop_q - 8'h01;
        halt_q <= (loop_q == 8'h01);
      end else if (wr_hit && wr_idx == rsc_pkg::IDX_LOOP_CNT) begin
        loop_q <= w_data_q[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      seq_operands_out <= '0;
      seq_halt_out     <= 1'b0;
    end else begin
      seq_operands_out <= '{x: x_q, y: y_q, z: z_q, condition: cond_q};
      seq_halt_out     <= halt_q;
    end
  end

  // microsecond enable shared by every delay
  assign us_tick = (us_div_q == 8'(rsc_pkg::US_CYCLES - 1));

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) us_div_q <= 8'h00;
    else us_div_q <= us_tick ? 8'h00 : us_div_q + 8'h01;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_off_q   <= rsc_pkg::RST_REG_OFF;
      reg_delay_q <= rsc_pkg::RST_REG_DELAY;
    end else if (wr_hit && wr_idx == rsc_pkg::IDX_REG_POWER) begin
      reg_off_q   <= w_data_q[rsc_pkg::POS_REG_OFF];
      reg_delay_q <= w_data_q[2:0];
    end
  end

  // power-up waits the chosen delay, up to 1 us short; power-down is at once
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_off_dly_q <= rsc_pkg::RST_REG_OFF;
      reg_cnt_q     <= 11'd0;
    end else if (reg_off_q) begin
      reg_off_dly_q <= 1'b1;
      reg_cnt_q     <= 11'd0;
    end else if (reg_off_dly_q) begin
      if (reg_cnt_q >= rsc_pkg::reg_delay_us(reg_delay_q)) reg_off_dly_q <= 1'b0;
      else if (us_tick) reg_cnt_q <= reg_cnt_q + 11'd1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx2demod_q <= rsc_pkg::RST_RX2DEMOD;
      sw_lead_q  <= rsc_pkg::RST_SW_LEAD;
      pa_lead_q  <= {rsc_pkg::RST_PA_LEAD_HI, rsc_pkg::RST_PA_LEAD_LO};
      end2sw_q   <= rsc_pkg::RST_END2SW;
      end2pa_q   <= rsc_pkg::RST_END2PA;
    end else if (wr_hit && wr_idx == rsc_pkg::IDX_TIMING_HI) begin
      rx2demod_q     <= w_data_q[rsc_pkg::POS_RX2DEMOD +: 3];
      sw_lead_q      <= w_data_q[rsc_pkg::POS_SW_LEAD +: 3];
      pa_lead_q[3:2] <= w_data_q[1:0];
    end else if (wr_hit && wr_idx == rsc_pkg::IDX_TIMING_LO) begin
      pa_lead_q[1:0] <= w_data_q[rsc_pkg::POS_PA_LEAD_LO +: 2];
      end2sw_q       <= w_data_q[rsc_pkg::POS_END2SW +: 3];
      end2pa_q       <= w_data_q[rsc_pkg::POS_END2PA +: 3];
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_state_q <= rsc_pkg::RX_IDLE;
      rx_cnt_q   <= 8'h00;
    end else if (!rx_request_in) begin
      rx_state_q <= rsc_pkg::RX_IDLE;
      rx_cnt_q   <= 8'h00;
    end else begin
      unique case (rx_state_q)
        rsc_pkg::RX_IDLE: begin
          rx_state_q <= rsc_pkg::RX_CAL;
        end
        rsc_pkg::RX_CAL: begin
          if (rx_cnt_q == 8'(rsc_pkg::CAL_US)) begin
            rx_state_q <= rsc_pkg::RX_CHAIN;
            rx_cnt_q   <= 8'h00;
          end else if (us_tick) rx_cnt_q <= rx_cnt_q + 8'h01;
        end
        rsc_pkg::RX_CHAIN: begin
          if (rx_cnt_q == 8'(rx2demod_q * rsc_pkg::RX_STEP_US)) rx_state_q <= rsc_pkg::RX_DEMOD;
          else if (us_tick) rx_cnt_q <= rx_cnt_q + 8'h01;
        end
        rsc_pkg::RX_DEMOD: rx_state_q <= rsc_pkg::RX_DEMOD;
      endcase
    end
  end

  // transmit: leads are counted back from TX enable
  assign lead_max = (pa_lead_q > {1'b0, sw_lead_q}) ? pa_lead_q : {1'b0, sw_lead_q};

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_state_q <= rsc_pkg::TX_IDLE;
      tx_cnt_q   <= 8'h00;
      sw_on_q    <= 1'b0;
      pa_on_q    <= 1'b0;
      tx_on_q    <= 1'b0;
      mod_on_q   <= 1'b0;
    end else begin
      unique case (tx_state_q)
        rsc_pkg::TX_IDLE: begin
          tx_cnt_q <= 8'h00;
          if (tx_request_in) tx_state_q <= rsc_pkg::TX_LEAD;
        end
        rsc_pkg::TX_LEAD: begin
          if (tx_cnt_q == 8'(lead_max - {1'b0, sw_lead_q})) sw_on_q <= 1'b1;
          if (tx_cnt_q == 8'(lead_max - pa_lead_q)) pa_on_q <= 1'b1;
          if (tx_cnt_q == 8'(lead_max)) begin
            tx_on_q    <= 1'b1;
            mod_on_q   <= 1'b1;
            tx_state_q <= rsc_pkg::TX_ON;
          end else if (us_tick) tx_cnt_q <= tx_cnt_q + 8'h01;
        end
        rsc_pkg::TX_ON: begin
          tx_cnt_q <= 8'h00;
          if (tx_last_chip_in) begin
            tx_on_q    <= 1'b0;
            tx_state_q <= rsc_pkg::TX_TAIL;
          end
        end
        rsc_pkg::TX_TAIL: begin
          if (tx_cnt_q >= 8'(end2sw_q)) sw_on_q <= 1'b0;
          if (tx_cnt_q >= 8'(end2pa_q)) begin
            pa_on_q  <= 1'b0;
            mod_on_q <= 1'b0;
          end
          if (tx_cnt_q >= 8'(end2sw_q) && tx_cnt_q >= 8'(end2pa_q)) tx_state_q <= rsc_pkg::TX_IDLE;
          else if (us_tick) tx_cnt_q <= tx_cnt_q + 8'h01;
        end
        default: tx_state_q <= rsc_pkg::TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) mask_q <= rsc_pkg::RST_AND_MASK;
    else if (wr_hit && wr_idx == rsc_pkg::IDX_AND_MASK_H) mask_q <= w_data_q[7:0] & rsc_pkg::RST_AND_MASK;
  end

  // all-ones mask leaves the state machine lines untouched
  always_comb begin
    lines.vga_reset_n          = mask_q[rsc_pkg::POS_VGA_RST_N] & (rx_state_q == rsc_pkg::RX_DEMOD);
    lines.pa_external_bias_ctl = mask_q[rsc_pkg::POS_EXT_BIAS] & pa_on_q;
    lines.buffer_select        = mask_q[rsc_pkg::POS_BUF_SEL] & sw_on_q;
    lines.prescaler_off        = mask_q[rsc_pkg::POS_PRESCALER] & reg_off_dly_q;
    lines.pa_negative_path_off = mask_q[rsc_pkg::POS_PA_NEG] & !pa_on_q;
    lines.pa_positive_path_off = mask_q[rsc_pkg::POS_PA_POS] & !pa_on_q;
    lines.tx_converter_off     = mask_q[rsc_pkg::POS_TX_DAC] & !mod_on_q;
    lines.upmixer_off          = lines.pa_negative_path_off & lines.pa_positive_path_off;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      analog_out        <= 8'h7f;
      regulator_off_out <= rsc_pkg::RST_REG_OFF;
      rx_chain_en_out   <= 1'b0;
      demod_en_out      <= 1'b0;
      tx_en_out         <= 1'b0;
      modulator_en_out  <= 1'b0;
    end else begin
      analog_out        <= lines;
      regulator_off_out <= reg_off_q;
      rx_chain_en_out   <= (rx_state_q == rsc_pkg::RX_CHAIN) || (rx_state_q == rsc_pkg::RX_DEMOD);
      demod_en_out      <= (rx_state_q == rsc_pkg::RX_DEMOD);
      tx_en_out         <= tx_on_q;
      modulator_en_out  <= mod_on_q;
    end
  end
endmodule // rsc_regs

// [verification/rsc_regs_props.sv]
// assertion checker for the radio sequencer register bank
`timescale 1ns/100ps
module rsc_regs_props (
  input wire logic                    sys_clk_in,
  input wire logic                    arst_n_in,
  input wire logic                    s_axi_rvalid_out,
  input wire logic                    s_axi_rready_in,
  input wire logic [31:0]             s_axi_rdata_out,
  input wire logic                    seq_running_in,
  input wire logic                    timer_overflow_in,
  input wire logic                    tx_last_chip_in,
  input wire logic                    seq_halt_out,
  input wire logic                    tx_en_out,
  input wire logic                    modulator_en_out,
  input wire logic                    demod_en_out,
  input wire rsc_pkg::rsc_analog_type analog_out
);
  logic live_q;
  // skip the first edge after release
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
    if (!arst_n_in) live_q <= 1'h0;
    else live_q <= 1'h1;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in || !live_q);
  sequence s_tx_end;
    tx_last_chip_in && tx_en_out;
  endsequence
  chk_halt_cause: assert property (seq_halt_out |-> $past(timer_overflow_in && seq_running_in, 2))
    else $error("halt without timer overflow");
  chk_halt_single: assert property (seq_halt_out |=> !seq_halt_out)
    else $error("halt longer than one cycle");
  chk_upmixer_off: assert property (
    analog_out.pa_negative_path_off && analog_out.pa_positive_path_off |-> analog_out.upmixer_off)
    else $error("mixers on with both paths off");
  chk_tx_mod_on: assert property (tx_en_out |-> modulator_en_out)
    else $error("tx without modulator");
  chk_lead_tx: assert property (
    tx_en_out |-> analog_out.buffer_select && !analog_out.pa_positive_path_off)
    else $error("tx before switch or pa");
  chk_tx_end: assert property (s_tx_end |-> ##[1:3] !tx_en_out)
    else $error("tx not stopped after last chip");
  chk_vga_demod: assert property (analog_out.vga_reset_n |-> demod_en_out)
    else $error("vga reset released without demod");
  chk_bias_paths: assert property (
    analog_out.pa_external_bias_ctl |-> !analog_out.pa_negative_path_off)
    else $error("bias with pa path off");
  chk_rdata_hold: assert property (
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read answer dropped");
endmodule // rsc_regs_props

// [verification/rsc_cpu_model.sv]
// processor-side register bus master model
`timescale 1ns/100ps
module rsc_cpu_model (
  input  wire logic                  sys_clk_in,
  output logic [rsc_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  output logic                       s_axi_awvalid_in,
  input  wire logic                  s_axi_awready_out,
  output logic [31:0]                s_axi_wdata_in,
  output logic [3:0]                 s_axi_wstrb_in,
  output logic                       s_axi_wvalid_in,
  input  wire logic                  s_axi_wready_out,
  input  wire logic [1:0]            s_axi_bresp_out,
  input  wire logic                  s_axi_bvalid_out,
  output logic                       s_axi_bready_in,
  output logic [rsc_pkg::ADDR_W-1:0] s_axi_araddr_in,
  output logic                       s_axi_arvalid_in,
  input  wire logic                  s_axi_arready_out,
  input  wire logic [31:0]           s_axi_rdata_out,
  input  wire logic [1:0]            s_axi_rresp_out,
  input  wire logic                  s_axi_rvalid_out,
  output logic                       s_axi_rready_in
);
  initial {s_axi_awaddr_in, s_axi_awvalid_in, s_axi_wdata_in, s_axi_wstrb_in, s_axi_wvalid_in,
           s_axi_bready_in, s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, output logic [1:0] r);
    @(posedge sys_clk_in);
    s_axi_awaddr_in <= {idx, 2'h0};
    s_axi_wdata_in <= {24'h00_0000, d};
    s_axi_wstrb_in <= 4'hf;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
    end while (!s_axi_bvalid_out);
    r = s_axi_bresp_out;
    s_axi_bready_in <= 1'h0;
  endtask
  task automatic rd(input logic [15:0] idx, output logic [7:0] d, output logic [1:0] r);
    @(posedge sys_clk_in);
    s_axi_araddr_in <= {idx, 2'h0};
    {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
    end while (!s_axi_rvalid_out);
    {d, r} = {s_axi_rdata_out[7:0], s_axi_rresp_out};
    s_axi_rready_in <= 1'h0;
  endtask
endmodule // rsc_cpu_model

// [verification/tb_top.sv]
// self-checking testbench for the radio sequencer register bank
`timescale 1ns/100ps
module tb_top;
  logic [rsc_pkg::ADDR_W-1:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
  logic sys_clk_in, arst_n_in, seq_running_in, timer_overflow_in, seq_y_load_in, seq_z_dec_in;
  logic rx_request_in, tx_request_in, tx_last_chip_in, seq_halt_out, regulator_off_out;
  logic rx_chain_en_out, demod_en_out, tx_en_out, modulator_en_out;
  logic [7:0] seq_y_value_in, d;
  rsc_pkg::rsc_operands_type seq_operands_out;
  rsc_pkg::rsc_analog_type   analog_out;
  int errors, samples_checked, n;
  typedef struct { logic [15:0] idx; logic [7:0] rst, wr, rb; logic [1:0] rs; } rsc_row_type;
  rsc_row_type rows [10] = '{
    '{16'hdf12, 8'h00, 8'ha5, 8'ha5, 2'h0}, '{16'hdf13, 8'h00, 8'h5a, 8'h5a, 2'h0},
    '{16'hdf14, 8'h00, 8'h3c, 8'h3c, 2'h0}, '{16'hdf15, 8'h00, 8'hff, 8'h01, 2'h0},
    '{16'hdf16, 8'h00, 8'h02, 8'h02, 2'h0}, '{16'hdf17, 8'h1c, 8'h0f, 8'h1f, 2'h0},
    '{16'hdf20, 8'h7a, 8'hff, 8'hff, 2'h0}, '{16'hdf21, 8'h94, 8'he5, 8'he5, 2'h0},
    '{16'hdf22, 8'hbf, 8'hff, 8'hbf, 2'h0}, '{16'hdf18, 8'h00, 8'h55, 8'h00, 2'h2}};
  rsc_regs      i_rsc_regs (.*);
  rsc_cpu_model i_rsc_cpu_model (.*);
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 40000) begin
      @(posedge sys_clk_in);
      c++;
    end
  endtask
  task automatic stop_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk_in);
  endtask
  initial begin
    sys_clk_in = 1'h0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  // about 1.5 times the longest run
  initial begin
    #300_000;
    errors++;
    stop_test();
  end
  initial begin
    {arst_n_in, seq_running_in, timer_overflow_in, seq_y_load_in, seq_z_dec_in} = '0;
    {rx_request_in, tx_request_in, tx_last_chip_in, seq_y_value_in} = '0;
    tick(12);
    arst_n_in <= 1'h1;
    foreach (rows[i]) begin
      i_rsc_cpu_model.rd(rows[i].idx, d, r);
      chk("reset value", d, rows[i].rst);
      chk("read resp", r, rows[i].rs);
      i_rsc_cpu_model.wr(rows[i].idx, rows[i].wr, r);
      chk("write resp", r, rows[i].rs);
      i_rsc_cpu_model.rd(rows[i].idx, d, r);
      chk("readback", d, rows[i].rb);
    end
    chk("op x", seq_operands_out.x, 8'ha5);
    chk("op cond", seq_operands_out.condition, 1'h1);
    chk("idle lines", analog_out, 8'h1f);
    seq_running_in <= 1'h1;
    timer_overflow_in <= 1'h1;
    tick(2);
    timer_overflow_in <= 1'h0;
    n = 0;
    repeat (4) begin
      @(posedge sys_clk_in);
      n += seq_halt_out;
    end
    chk("halt pulses", n, 1);
    i_rsc_cpu_model.rd(16'hdf16, d, r);
    chk("loop after", d, 8'h00);
    i_rsc_cpu_model.wr(16'hdf16, 8'hff, r);
    timer_overflow_in <= 1'h1;
    tick(2);
    timer_overflow_in <= 1'h0;
    i_rsc_cpu_model.rd(16'hdf16, d, r);
    chk("loop held", d, 8'hff);
    {seq_y_load_in, seq_z_dec_in, seq_y_value_in} <= {2'h3, 8'h77};
    tick(1);
    {seq_y_load_in, seq_z_dec_in} <= 2'h0;
    tick(3);
    chk("op y", seq_operands_out.y, 8'h77);
    chk("op z", seq_operands_out.z, 8'h3b);
    i_rsc_cpu_model.wr(16'hdf22, 8'h00, r);
    tick(3);
    chk("masked lines", analog_out, 8'h00);
    i_rsc_cpu_model.wr(16'hdf22, 8'hff, r);
    chk("reg off", regulator_off_out, 1'h1);
    i_rsc_cpu_model.wr(16'hdf17, 8'h01, r);
    tick(5800);
    chk("reg off now", regulator_off_out, 1'h0);
    i_rsc_cpu_model.rd(16'hdf17, d, r);
    chk("delayed off", d, 8'h11);
    tick(600);
    i_rsc_cpu_model.rd(16'hdf17, d, r);
    chk("delayed on", d, 8'h01);
    tx_request_in <= 1'h1;
    tick(1);
    tx_request_in <= 1'h0;
    wt(tx_en_out, 1'h1, n);
    chk("pa lead", n >= 2800 && n <= 3010, 1'h1);
    tx_last_chip_in <= 1'h1;
    tick(1);
    tx_last_chip_in <= 1'h0;
    wt(modulator_en_out, 1'h0, n);
    chk("pa off delay", n >= 800 && n <= 1010, 1'h1);
    rx_request_in <= 1'h1;
    wt(rx_chain_en_out, 1'h1, n);
    chk("calibration", n >= 20600 && n <= 20810, 1'h1);
    wt(demod_en_out, 1'h1, n);
    chk("demod delay", n >= 6800 && n <= 7010, 1'h1);
    tick(3);
    chk("vga release", analog_out.vga_reset_n, 1'h1);
    arst_n_in <= 1'h0;
    tick(2);
    chk("reset lines", analog_out, 8'h7f);
    arst_n_in <= 1'h1;
    rx_request_in <= 1'h0;
    i_rsc_cpu_model.rd(16'hdf12, d, r);
    chk("x after reset", d, 8'h00);
    stop_test();
  end
endmodule // tb_top
bind rsc_regs rsc_regs_props i_rsc_regs_props (.*);
